// *** logic/buf_ram.v ***
`timescale 1ns/1ps
`default_nettype none
// Two-port byte store; each port reads through a register.
module buf_ram #(
	parameter DW    = 8,
	parameter AW    = 8,
	parameter DEPTH = 160
) (
	// Clock
	input  wire          clk_in,
	// Port A
	input  wire          a_we_in,
	input  wire [AW-1:0] a_addr_in,
	input  wire [DW-1:0] a_wdata_in,
	output reg  [DW-1:0] a_rdata_out,
	// Port B
	input  wire          b_we_in,
	input  wire [AW-1:0] b_addr_in,
	input  wire [DW-1:0] b_wdata_in,
	output reg  [DW-1:0] b_rdata_out
);
	reg [DW-1:0] mem [0:DEPTH-1];

	// Port B wins when both ports write the same byte.
	always @(posedge clk_in)
	begin
		if (a_we_in)
			mem[a_addr_in] <= a_wdata_in;
		if (b_we_in)
			mem[b_addr_in] <= b_wdata_in;
		a_rdata_out <= mem[a_addr_in];
		b_rdata_out <= mem[b_addr_in];
	end
endmodule
`default_nettype wire

// *** logic/host_cmd_port.v ***
`timescale 1ns/1ps
`default_nettype none
`include "host_port_defs.vh"
module host_cmd_port #(
	parameter RESET_HOLD_CYCLES = `RESET_HOLD_CYCLES
) (
	// Clock and resets
	input  wire        ref_clk_in,
	input  wire        reset_in,
	input  wire        ext_reset_in,
	output reg         reset_state_out_high,
	output reg         reset_state_out_low,
	// Parallel host port
	input  wire        select_n_in,
	input  wire        store_strobe_n_in,
	input  wire        read_strobe_n_in,
	input  wire        port_select_line_in,
	input  wire [7:0]  data_bus_in,
	output reg  [7:0]  data_bus_out,
	output reg         data_bus_oe_out,
	output wire        irq_out_n,
	// Serial host port; the transmit pin also carries the mode strap
	input  wire        serial_rx_in,
	input  wire        serial_pin_in,
	output wire        serial_pin_out,
	output reg         serial_pin_oe_out,
	// Clocking and status led
	input  wire        osc_input_in,
	output reg         osc_output_out,
	output wire        usb_ref_out,
	output reg         link_state_led_out,
	// Command engine side
	input  wire        device_mode_req_in,
	input  wire        attached_in,
	input  wire        configured_in,
	input  wire        usb_change_in,
	input  wire        cmd_done_in,
	output reg         device_mode_out,
	output reg         serial_mode_out,
	output reg         cmd_valid_out,
	output reg  [7:0]  cmd_code_out,
	output reg         data_valid_out,
	output reg  [7:0]  data_byte_out,
	input  wire [7:0]  resp_byte_in,
	input  wire        resp_send_in,
	input  wire        block_start_in,
	input  wire [6:0]  block_len_in,
	input  wire        core_buf_we_in,
	input  wire [7:0]  core_buf_addr_in,
	input  wire [7:0]  core_buf_wdata_in,
	output wire [7:0]  core_buf_rdata_out
);
	localparam integer LINE_DIV_I = `LINE_DIV_RESET;
	localparam integer NCO_STEP_I = `NCO_STEP;
	localparam [15:0]  LINE_DIV0  = LINE_DIV_I[15:0];
	localparam [15:0]  NCO_INC    = NCO_STEP_I[15:0];
	localparam [1:0]  SPD_IDLE  = 2'd0;
	localparam [1:0]  SPD_LOW   = 2'd1;
	localparam [1:0]  SPD_HIGH  = 2'd2;

	reg [31:0] hold_cnt_reg;
	reg        in_reset_reg;
	reg        irq_n_reg;
	reg        wr_cyc_reg;
	reg        wr_a0_reg;
	reg [7:0]  wr_byte_reg;
	reg        rd_cyc_reg;
	reg        rd_a0_reg;
	reg        len_phase_reg;
	reg [6:0]  blk_len_reg;
	reg [6:0]  blk_left_reg;
	reg [5:0]  rptr_reg;
	reg [6:0]  wptr_reg;
	reg        tx_pend_reg;
	reg [1:0]  spd_state_reg;
	reg [7:0]  spd_low_reg;
	reg [15:0] line_div_reg;
	reg [15:0] nco_reg;
	reg [7:0]  next_byte;
	wire       rst;
	wire       wr_cyc;
	wire       rd_cyc;
	wire       par_wr_done;
	wire       rx_valid;
	wire [8:0] rx_data;
	wire       tx_busy;
	wire       tx_start;
	wire       take;
	wire       wr_ev;
	wire       wr_is_cmd;
	wire [7:0] wr_byte;
	wire       buf_we;
	wire [7:0] buf_addr;
	wire [7:0] buf_rdata;
	wire [6:0] len_clamped;

	// ------------------------------------------------------------
	// Reset stretch and mode strap
	// ------------------------------------------------------------
	// Only the hold counter sees the external reset directly; all
	// other logic restarts from the synchronous in_reset_reg.
	always @(posedge ref_clk_in or posedge ext_reset_in)
	begin
		if (ext_reset_in)
		begin
			hold_cnt_reg <= 32'h00000000;
			in_reset_reg <= 1'b1;
		end
		else if (reset_in)
		begin
			hold_cnt_reg <= 32'h00000000;
			in_reset_reg <= 1'b1;
		end
		else if (hold_cnt_reg < RESET_HOLD_CYCLES - 1)
		begin
			hold_cnt_reg <= hold_cnt_reg + 32'h00000001;
			in_reset_reg <= 1'b1;
		end
		else
			in_reset_reg <= 1'b0;
	end

	assign rst = in_reset_reg;

	always @(posedge ref_clk_in)
	begin
		reset_state_out_high <= rst;
		reset_state_out_low  <= ~rst;
		// The strap is followed for the whole reset, so its last level wins.
		if (rst)
			serial_mode_out <= serial_pin_in;
		serial_pin_oe_out <= serial_mode_out & ~rst;
		if (rst)
			device_mode_out <= 1'b0;
		else
			device_mode_out <= device_mode_req_in & ~serial_mode_out;
		if (rst)
			link_state_led_out <= 1'b1;
		else if (device_mode_out)
			link_state_led_out <= ~configured_in;
		else
			link_state_led_out <= ~attached_in;
	end

	// ------------------------------------------------------------
	// Reference clock from the core clock; crystal input inverter
	// ------------------------------------------------------------
	// A digital core cannot hold a true PLL; a phase accumulator
	// gives a 48 MHz reference with one-cycle jitter instead.
	always @(posedge ref_clk_in)
	begin
		osc_output_out <= ~osc_input_in;
		if (rst)
			nco_reg <= 16'h0000;
		else
			nco_reg <= nco_reg + NCO_INC;
	end

	assign usb_ref_out = nco_reg[15];

	// ------------------------------------------------------------
	// Parallel strobe decode
	// ------------------------------------------------------------
	// A write ignores the read strobe, so hosts with one direction
	// line may hold read low.
	assign wr_cyc = ~select_n_in & ~store_strobe_n_in & ~serial_mode_out;
	assign rd_cyc = ~select_n_in & store_strobe_n_in & ~read_strobe_n_in
		& ~serial_mode_out;
	assign par_wr_done = wr_cyc_reg & ~wr_cyc;

	always @(posedge ref_clk_in)
	begin
		if (rst)
		begin
			wr_cyc_reg      <= 1'b0;
			wr_a0_reg       <= 1'b0;
			wr_byte_reg     <= 8'h00;
			rd_cyc_reg      <= 1'b0;
			rd_a0_reg       <= 1'b0;
			data_bus_out    <= 8'h00;
			data_bus_oe_out <= 1'b0;
		end
		else
		begin
			wr_cyc_reg      <= wr_cyc;
			rd_cyc_reg      <= rd_cyc;
			data_bus_oe_out <= rd_cyc;
			// Byte and port are loaded on every cycle of the strobe, so the level just before its trailing edge is kept.
			if (wr_cyc)
			begin
				wr_a0_reg   <= port_select_line_in;
				wr_byte_reg <= data_bus_in;
			end
			if (rd_cyc & ~rd_cyc_reg)
			begin
				rd_a0_reg <= port_select_line_in;
				if (port_select_line_in)
					data_bus_out <= {irq_n_reg, 7'h00};
				else
					data_bus_out <= next_byte;
			end
		end
	end

	// ------------------------------------------------------------
	// Serial link
	// ------------------------------------------------------------
	line_uart u_uart (
		.ref_clk_in   (ref_clk_in),
		.reset_in     (rst),
		.div_in       (line_div_reg),
		.rx_in        (serial_rx_in),
		.rx_valid_out (rx_valid),
		.rx_data_out  (rx_data),
		.tx_start_in  (tx_start),
		.tx_data_in   ({1'b0, next_byte}),
		.tx_busy_out  (tx_busy),
		.tx_out       (serial_pin_out)
	);

	// Output bytes are pushed on the serial link as they become due.
	assign tx_start = serial_mode_out & tx_pend_reg & ~tx_busy;

	// ------------------------------------------------------------
	// Host byte stream
	// ------------------------------------------------------------
	assign wr_ev     = serial_mode_out ? rx_valid : par_wr_done;
	assign wr_is_cmd = serial_mode_out ? rx_data[`CMD_FLAG_BIT] : wr_a0_reg;
	assign wr_byte   = serial_mode_out ? rx_data[7:0] : wr_byte_reg;
	assign take      = serial_mode_out ? tx_start : (rd_cyc_reg & ~rd_cyc & ~rd_a0_reg);

	// Input bytes following a command also land in the host output
	// buffer, so a block write needs no further copy by the engine.
	assign buf_we   = wr_ev & ~wr_is_cmd & ~wptr_reg[6];
	assign buf_addr = buf_we ? (`BUF_EP2_UP_BASE + {1'b0, wptr_reg})
		: (`BUF_EP2_DN_BASE + {2'b00, rptr_reg});
	assign len_clamped = (block_len_in > `BLOCK_MAX_LEN) ? `BLOCK_MAX_LEN
		: block_len_in;

	always @*
	begin
		if (len_phase_reg)
			next_byte = {1'b0, blk_len_reg};
		else if (blk_left_reg != 7'h00)
			next_byte = buf_rdata;
		else
			next_byte = resp_byte_in;
	end

	always @(posedge ref_clk_in)
	begin
		cmd_valid_out  <= 1'b0;
		data_valid_out <= 1'b0;
		if (rst)
		begin
			cmd_code_out  <= 8'h00;
			data_byte_out <= 8'h00;
			wptr_reg      <= 7'h00;
			spd_state_reg <= SPD_IDLE;
			spd_low_reg   <= 8'h00;
			line_div_reg  <= LINE_DIV0;
		end
		else if (wr_ev & wr_is_cmd)
		begin
			cmd_valid_out <= 1'b1;
			cmd_code_out  <= wr_byte;
			wptr_reg      <= 7'h00;
			if (wr_byte == `CMD_SET_LINE_SPEED)
				spd_state_reg <= SPD_LOW;
			else
				spd_state_reg <= SPD_IDLE;
		end
		else if (wr_ev)
		begin
			data_valid_out <= 1'b1;
			data_byte_out  <= wr_byte;
			if (!wptr_reg[6])
				wptr_reg <= wptr_reg + 7'h01;
			case (spd_state_reg)
				SPD_LOW:
				begin
					spd_low_reg   <= wr_byte;
					spd_state_reg <= SPD_HIGH;
				end
				SPD_HIGH:
				begin
					// A zero period would stall the link; keep the old one.
					if ({wr_byte, spd_low_reg} != 16'h0000)
						line_div_reg <= {wr_byte, spd_low_reg};
					spd_state_reg <= SPD_IDLE;
				end
				default:
					spd_state_reg <= SPD_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Output block sequencing
	// ------------------------------------------------------------
	always @(posedge ref_clk_in)
	begin
		if (rst)
		begin
			len_phase_reg <= 1'b0;
			blk_len_reg   <= 7'h00;
			blk_left_reg  <= 7'h00;
			rptr_reg      <= 6'h00;
			tx_pend_reg   <= 1'b0;
		end
		else if (block_start_in)
		begin
			len_phase_reg <= 1'b1;
			blk_len_reg   <= len_clamped;
			blk_left_reg  <= len_clamped;
			rptr_reg      <= 6'h00;
			tx_pend_reg   <= 1'b1;
		end
		else
		begin
			if (resp_send_in)
				tx_pend_reg <= 1'b1;
			else if (take & ((len_phase_reg & (blk_left_reg == 7'h00))
				| (~len_phase_reg & (blk_left_reg <= 7'h01))))
				tx_pend_reg <= 1'b0;
			if (take)
			begin
				if (len_phase_reg)
					len_phase_reg <= 1'b0;
				else if (blk_left_reg != 7'h00)
				begin
					blk_left_reg <= blk_left_reg - 7'h01;
					rptr_reg     <= rptr_reg + 6'h01;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupt request
	// ------------------------------------------------------------
	// A new event in the cycle of a status fetch keeps the line low.
	always @(posedge ref_clk_in)
	begin
		if (rst)
			irq_n_reg <= 1'b1;
		else if (usb_change_in | cmd_done_in)
			irq_n_reg <= 1'b0;
		else if (wr_ev & wr_is_cmd & (wr_byte == `CMD_GET_STATUS))
			irq_n_reg <= 1'b1;
	end

	assign irq_out_n = irq_n_reg;

	// ------------------------------------------------------------
	// Endpoint buffer store
	// ------------------------------------------------------------
	// Map: ep2 up (host out), ep2 down (host in), ep0, ep1.
	buf_ram #(
		.DW    (8),
		.AW    (`BUF_AW),
		.DEPTH (`BUF_DEPTH)
	) u_buf (
		.clk_in      (ref_clk_in),
		.a_we_in     (buf_we),
		.a_addr_in   (buf_addr),
		.a_wdata_in  (wr_byte),
		.a_rdata_out (buf_rdata),
		.b_we_in     (core_buf_we_in),
		.b_addr_in   (core_buf_addr_in),
		.b_wdata_in  (core_buf_wdata_in),
		.b_rdata_out (core_buf_rdata_out)
	);
endmodule
`default_nettype wire

// *** logic/host_port_defs.vh ***
`ifndef HOST_PORT_DEFS_VH
`define HOST_PORT_DEFS_VH
`define CLK_MHZ            250
`define RESET_HOLD_MS      20
`define RESET_HOLD_CYCLES  (`RESET_HOLD_MS * `CLK_MHZ * 1000)
`define LINE_RATE_BPS      9600
`define LINE_DIV_RESET     (`CLK_MHZ * 1000000 / `LINE_RATE_BPS)
`define FRAME_BITS         11
`define CMD_FLAG_BIT       8
`define TOKEN_IRQ_BIT      7
`define CMD_SET_LINE_SPEED 8'h02
`define CMD_GET_STATUS     8'h22
`define BLOCK_MAX_LEN      7'h40
`define ENDP_NUM_BITS      4
`define BUF_AW             8
`define BUF_DEPTH          160
`define BUF_EP2_UP_BASE    8'h00
`define BUF_EP2_DN_BASE    8'h40
`define BUF_EP0_BASE       8'h80
`define BUF_EP1_BASE       8'h90
`define EP01_BUF_LEN       8
`define EP2_BUF_LEN        64
`define OSC_IN_MHZ         12
`define USB_REF_MHZ        48
`define NCO_STEP           (`USB_REF_MHZ * 65536 / `CLK_MHZ)
`endif

// *** logic/line_uart.v ***
`timescale 1ns/1ps
`default_nettype none
`include "host_port_defs.vh"
module line_uart (
	// Clock and reset
	input  wire        ref_clk_in,
	input  wire        reset_in,
	// Bit period in clock cycles
	input  wire [15:0] div_in,
	// Receive
	input  wire        rx_in,
	output reg         rx_valid_out,
	output reg  [8:0]  rx_data_out,
	// Transmit
	input  wire        tx_start_in,
	input  wire [8:0]  tx_data_in,
	output reg         tx_busy_out,
	output wire        tx_out
);
	reg        rx_s1_reg;
	reg        rx_s2_reg;
	reg        rx_busy_reg;
	reg [15:0] rx_cnt_reg;
	reg [3:0]  rx_bit_reg;
	reg [8:0]  rx_sh_reg;
	reg [15:0] tx_cnt_reg;
	reg [3:0]  tx_bit_reg;
	reg [10:0] tx_sh_reg;
	localparam integer LAST_BIT = `FRAME_BITS - 1;

	// ------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------
	always @(posedge ref_clk_in)
	begin
		rx_s1_reg    <= rx_in;
		rx_s2_reg    <= rx_s1_reg;
		rx_valid_out <= 1'b0;
		if (reset_in)
		begin
			rx_busy_reg <= 1'b0;
			rx_cnt_reg  <= 16'h0000;
			rx_bit_reg  <= 4'h0;
			rx_sh_reg   <= 9'h000;
			rx_data_out <= 9'h000;
		end
		else if (!rx_busy_reg)
		begin
			if (!rx_s2_reg)
			begin
				rx_busy_reg <= 1'b1;
				rx_cnt_reg  <= {1'b0, div_in[15:1]};
				rx_bit_reg  <= 4'h0;
			end
		end
		else if (rx_cnt_reg != 16'h0000)
			rx_cnt_reg <= rx_cnt_reg - 16'h0001;
		else
		begin
			rx_cnt_reg <= div_in - 16'h0001;
			// A start bit that is high again at mid-bit was a glitch.
			if (rx_bit_reg == 4'h0)
			begin
				if (rx_s2_reg)
					rx_busy_reg <= 1'b0;
				else
					rx_bit_reg <= 4'h1;
			end
			else if (rx_bit_reg <= 4'h9)
			begin
				rx_sh_reg  <= {rx_s2_reg, rx_sh_reg[8:1]};
				rx_bit_reg <= rx_bit_reg + 4'h1;
			end
			else
			begin
				// Frames with a bad stop bit are dropped.
				rx_busy_reg  <= 1'b0;
				rx_valid_out <= rx_s2_reg;
				rx_data_out  <= rx_sh_reg;
			end
		end
	end

	// ------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------
	always @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			tx_busy_out <= 1'b0;
			tx_cnt_reg  <= 16'h0000;
			tx_bit_reg  <= 4'h0;
			tx_sh_reg   <= 11'h7FF;
		end
		else if (!tx_busy_out)
		begin
			if (tx_start_in)
			begin
				tx_busy_out <= 1'b1;
				tx_sh_reg   <= {1'b1, tx_data_in, 1'b0};
				tx_cnt_reg  <= div_in - 16'h0001;
				tx_bit_reg  <= 4'h0;
			end
		end
		else if (tx_cnt_reg != 16'h0000)
			tx_cnt_reg <= tx_cnt_reg - 16'h0001;
		else
		begin
			tx_cnt_reg <= div_in - 16'h0001;
			tx_sh_reg  <= {1'b1, tx_sh_reg[10:1]};
			tx_bit_reg <= tx_bit_reg + 4'h1;
			if (tx_bit_reg == LAST_BIT[3:0])
				tx_busy_out <= 1'b0;
		end
	end

	assign tx_out = tx_busy_out ? tx_sh_reg[0] : 1'b1;
endmodule
`default_nettype wire

// *** verif/host_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
	// Clock
	input  wire logic       ref_clk_in,
	// Host-driven lines
	output var  logic       select_n_out,
	output var  logic       store_strobe_n_out,
	output var  logic       read_strobe_n_out,
	output var  logic       port_select_line_out,
	output var  logic [7:0] host_data_out,
	// Resolved data bus
	input  wire logic [7:0] bus_in
);
	initial
	begin
		select_n_out = 1'b1;
		store_strobe_n_out = 1'b1;
		read_strobe_n_out = 1'b1;
		port_select_line_out = 1'b0;
		host_data_out = 8'h00;
	end
	// Strobes stay low three cycles and high two, so the device sees every edge.
	task automatic wr(input logic ps, input logic [7:0] b, input logic comb, input logic sel);
		@(negedge ref_clk_in);
		select_n_out <= !sel;
		port_select_line_out <= ps;
		host_data_out <= b;
		read_strobe_n_out <= !comb;
		store_strobe_n_out <= 1'b0;
		repeat (3) @(negedge ref_clk_in);
		select_n_out <= 1'b1;
		store_strobe_n_out <= 1'b1;
		read_strobe_n_out <= 1'b1;
		host_data_out <= ~b;
		repeat (2) @(negedge ref_clk_in);
	endtask
	task automatic rd(input logic ps, output logic [7:0] b);
		@(negedge ref_clk_in);
		select_n_out <= 1'b0;
		port_select_line_out <= ps;
		read_strobe_n_out <= 1'b0;
		repeat (3) @(negedge ref_clk_in);
		b = bus_in;
		select_n_out <= 1'b1;
		read_strobe_n_out <= 1'b1;
		repeat (2) @(negedge ref_clk_in);
	endtask
endmodule
`default_nettype wire

// *** verif/host_cmd_port_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_cmd_port_props #(
	parameter RESET_HOLD_CYCLES = 20
) (
	// Clock and resets
	input wire logic       ref_clk_in,
	input wire logic       reset_in,
	input wire logic       ext_reset_in,
	input wire logic       reset_state_out_high,
	input wire logic       reset_state_out_low,
	// Parallel port
	input wire logic       select_n_in,
	input wire logic       store_strobe_n_in,
	input wire logic       read_strobe_n_in,
	input wire logic       port_select_line_in,
	input wire logic [7:0] data_bus_out,
	input wire logic       data_bus_oe_out,
	input wire logic       irq_out_n,
	// Engine side
	input wire logic       link_state_led_out,
	input wire logic       attached_in,
	input wire logic       configured_in,
	input wire logic       usb_change_in,
	input wire logic       cmd_done_in,
	input wire logic       device_mode_out,
	input wire logic       serial_mode_out,
	input wire logic       cmd_valid_out,
	input wire logic [7:0] cmd_code_out,
	input wire logic       data_valid_out
);
	// Counts edges spent in the hold after both resets are gone.
	reg  [31:0] quiet_reg;
	wire        idle_bus = select_n_in | (store_strobe_n_in & read_strobe_n_in);
	wire        ev       = usb_change_in | cmd_done_in;
	always @(posedge ref_clk_in)
		if (reset_in | ext_reset_in)
			quiet_reg <= 32'h0;
		else if (reset_state_out_high)
			quiet_reg <= quiet_reg + 32'h1;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	property p_oe_read;
		data_bus_oe_out |-> $past(!select_n_in && !read_strobe_n_in && store_strobe_n_in);
	endproperty
	a_oe_read: assert property (p_oe_read) else $error("bus driven outside read");
	property p_rst_pair;
		reset_state_out_high != reset_state_out_low;
	endproperty
	a_rst_pair: assert property (p_rst_pair) else $error("reset outputs agree");
	property p_rst_enter;
		ext_reset_in |=> reset_state_out_high;
	endproperty
	a_rst_enter: assert property (p_rst_enter) else $error("ext reset not seen");
	property p_rst_hold;
		$fell(reset_state_out_high) |->
			quiet_reg >= RESET_HOLD_CYCLES && quiet_reg <= RESET_HOLD_CYCLES + 2;
	endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("reset hold length wrong");
	property p_led;
		($stable(attached_in) && $stable(configured_in) && $stable(device_mode_out)
			&& !reset_state_out_high) [*3] |->
			link_state_led_out == (device_mode_out ? !configured_in : !attached_in);
	endproperty
	a_led: assert property (p_led) else $error("led level wrong");
	property p_serial_host;
		serial_mode_out && !reset_state_out_high |-> !device_mode_out;
	endproperty
	a_serial_host: assert property (p_serial_host) else $error("device mode in serial");
	property p_irq_set;
		ev && !reset_state_out_high && !ext_reset_in |=> !irq_out_n;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("irq not raised");
	property p_irq_clear;
		cmd_valid_out && cmd_code_out == 8'h22 && !$past(ev) |-> irq_out_n;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared");
	property p_token;
		$rose(data_bus_oe_out) && $past(port_select_line_in) |->
			data_bus_out == {$past(irq_out_n), 7'h00};
	endproperty
	a_token: assert property (p_token) else $error("token byte wrong");
	property p_cmd_take;
		(!select_n_in && !store_strobe_n_in && port_select_line_in && !serial_mode_out
			&& !reset_state_out_high) ##1 store_strobe_n_in |-> ##[0:2] cmd_valid_out;
	endproperty
	a_cmd_take: assert property (p_cmd_take) else $error("command not taken");
	property p_data_take;
		(!select_n_in && !store_strobe_n_in && !port_select_line_in && !serial_mode_out
			&& !reset_state_out_high) ##1 store_strobe_n_in |-> ##[0:2] data_valid_out;
	endproperty
	a_data_take: assert property (p_data_take) else $error("data not taken");
	property p_idle;
		(idle_bus && !serial_mode_out) [*4] |->
			!cmd_valid_out && !data_valid_out && !data_bus_oe_out;
	endproperty
	a_idle: assert property (p_idle) else $error("activity while idle");
	c_status: cover property (cmd_valid_out && cmd_code_out == 8'h22);
	c_token: cover property ($rose(data_bus_oe_out) && $past(port_select_line_in));
	c_data: cover property (data_valid_out);
	c_hold: cover property ($fell(reset_state_out_high));
endmodule
bind host_cmd_port host_cmd_port_props #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)) i_props (
	.ref_clk_in, .reset_in, .ext_reset_in, .reset_state_out_high, .reset_state_out_low,
	.select_n_in, .store_strobe_n_in, .read_strobe_n_in, .port_select_line_in,
	.data_bus_out, .data_bus_oe_out, .irq_out_n, .link_state_led_out, .attached_in,
	.configured_in, .usb_change_in, .cmd_done_in, .device_mode_out, .serial_mode_out,
	.cmd_valid_out, .cmd_code_out, .data_valid_out
);
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int HOLD = 20;
	logic       ref_clk_in, reset_in, ext_reset_in, strap, osc_input_in, serial_rx_in;
	logic       device_mode_req_in, attached_in, configured_in, usb_change_in, cmd_done_in;
	logic       resp_send_in, block_start_in, core_buf_we_in;
	logic [7:0] resp_byte_in, core_buf_addr_in, core_buf_wdata_in, b;
	logic [6:0] block_len_in;
	logic [7:0] d [8];
	logic [7:0] cq [$];
	logic [7:0] dq [$];
	logic [31:0] seed;
	int         n_errors, n_compared, cycles, n, i, k;
	wire        select_n_in, store_strobe_n_in, read_strobe_n_in, port_select_line_in;
	wire        reset_state_out_high, reset_state_out_low, data_bus_oe_out, irq_out_n;
	wire        serial_pin_out, serial_pin_oe_out, osc_output_out, usb_ref_out;
	wire        link_state_led_out, device_mode_out, serial_mode_out, cmd_valid_out;
	wire        data_valid_out;
	wire [7:0]  data_bus_out, host_data, cmd_code_out, data_byte_out, core_buf_rdata_out;
	wire [7:0]  data_bus_in = data_bus_oe_out ? data_bus_out : host_data;
	wire        serial_pin_in = serial_pin_oe_out ? serial_pin_out : strap;
	host_cmd_port #(.RESET_HOLD_CYCLES(HOLD)) i_dut (
		.ref_clk_in, .reset_in, .ext_reset_in, .reset_state_out_high, .reset_state_out_low,
		.select_n_in, .store_strobe_n_in, .read_strobe_n_in, .port_select_line_in,
		.data_bus_in, .data_bus_out, .data_bus_oe_out, .irq_out_n, .serial_rx_in,
		.serial_pin_in, .serial_pin_out, .serial_pin_oe_out, .osc_input_in, .osc_output_out,
		.usb_ref_out, .link_state_led_out, .device_mode_req_in, .attached_in, .configured_in,
		.usb_change_in, .cmd_done_in, .device_mode_out, .serial_mode_out, .cmd_valid_out,
		.cmd_code_out, .data_valid_out, .data_byte_out, .resp_byte_in, .resp_send_in,
		.block_start_in, .block_len_in, .core_buf_we_in, .core_buf_addr_in,
		.core_buf_wdata_in, .core_buf_rdata_out
	);
	host_bus_model i_host (
		.ref_clk_in, .select_n_out(select_n_in), .store_strobe_n_out(store_strobe_n_in),
		.read_strobe_n_out(read_strobe_n_in), .port_select_line_out(port_select_line_in),
		.host_data_out(host_data), .bus_in(data_bus_in)
	);
	initial
	begin
		ref_clk_in = 1'b0;
		forever #2 ref_clk_in = ~ref_clk_in;
	end
	initial
	begin
		osc_input_in = 1'b0;
		forever #41.667 osc_input_in = ~osc_input_in;
	end
	// -------------------------------------------------------------
	// Monitors, checks and closing
	// -------------------------------------------------------------
	always @(posedge ref_clk_in)
	begin
		cycles++;
		if (cmd_valid_out === 1'b1)
			cq.push_back(cmd_code_out);
		if (data_valid_out === 1'b1)
			dq.push_back(data_byte_out);
		if (cycles == 5000)
		begin
			n_errors++;
			close_out();
		end
	end
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
			n_errors++;
		end
	endtask
	task automatic close_out();
		if (n_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic pulse(input logic [3:0] m);
		@(negedge ref_clk_in) {cmd_done_in, usb_change_in, block_start_in, resp_send_in} <= m;
		@(negedge ref_clk_in) {cmd_done_in, usb_change_in, block_start_in, resp_send_in} <= 4'h0;
		repeat (3) @(negedge ref_clk_in);
	endtask
	task automatic wait_hold();
		n = 0;
		while (reset_state_out_high !== 1'b0 && n < 100)
		begin
			@(negedge ref_clk_in);
			n++;
		end
		repeat (2) @(negedge ref_clk_in);
	endtask
	task automatic do_reset(input logic lvl);
		@(negedge ref_clk_in);
		reset_in <= 1'b1;
		strap <= lvl;
		repeat (10) @(negedge ref_clk_in);
		reset_in <= 1'b0;
		@(negedge ref_clk_in);
		check(reset_state_out_high, 1'b1);
		check(irq_out_n, 1'b1);
		wait_hold();
		check(reset_state_out_low, 1'b1);
		check(serial_mode_out, lvl);
	endtask
	// -------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------
	initial
	begin
		{reset_in, strap, serial_rx_in} = 3'b101;
		{ext_reset_in, device_mode_req_in, attached_in, configured_in} = 4'h0;
		{usb_change_in, cmd_done_in, resp_send_in, block_start_in, core_buf_we_in} = 5'h0;
		{resp_byte_in, core_buf_addr_in, core_buf_wdata_in, block_len_in} = 31'h0;
		{n_errors, n_compared, cycles} = 0;
		seed = 32'h370FDB6B;
		do_reset(1'b0);
		check(serial_pin_oe_out, 1'b0);
		check(link_state_led_out, 1'b1);
		seed = nxt(seed);
		d[7] = {1'b1, seed[6:0]};
		i_host.wr(1'b1, d[7], 1'b1, 1'b1);
		for (i = 0; i < 6; i++)
		begin
			seed = nxt(seed);
			d[i] = seed[7:0];
			i_host.wr(1'b0, d[i], 1'b0, 1'b1);
		end
		i_host.wr(1'b0, 8'hA5, 1'b0, 1'b0);
		i_host.wr(1'b1, 8'h5A, 1'b0, 1'b0);
		check(cq.size(), 1);
		check(cq[0], d[7]);
		check(dq.size(), 6);
		for (i = 0; i < 6; i++)
		begin
			check(dq[i], d[i]);
			@(negedge ref_clk_in) core_buf_addr_in <= i[7:0];
			@(negedge ref_clk_in) check(core_buf_rdata_out, d[i]);
		end
		i_host.rd(1'b1, b);
		check(b, 8'h80);
		pulse(4'h8);
		check(irq_out_n, 1'b0);
		i_host.rd(1'b1, b);
		check(b, 8'h00);
		i_host.wr(1'b1, 8'h22, 1'b0, 1'b1);
		check(irq_out_n, 1'b1);
		pulse(4'h4);
		check(irq_out_n, 1'b0);
		for (k = 0; k < 2; k++)
		begin
			i_host.wr(1'b1, 8'hC0, 1'b0, 1'b1);
			seed = nxt(seed);
			resp_byte_in <= seed[15:8];
			for (i = 0; i < 5; i++)
			begin
				seed = nxt(seed);
				d[i] = seed[7:0];
				@(negedge ref_clk_in);
				core_buf_we_in <= 1'b1;
				core_buf_addr_in <= 8'h40 + i[7:0];
				core_buf_wdata_in <= d[i];
			end
			@(negedge ref_clk_in) core_buf_we_in <= 1'b0;
			block_len_in <= 7'(k * 5);
			pulse(4'h2);
			i_host.rd(1'b0, b);
			check(b, k * 5);
			for (i = 0; i < k * 5; i++)
			begin
				i_host.rd(1'b0, b);
				check(b, d[i]);
			end
			i_host.rd(1'b0, b);
			check(b, resp_byte_in);
		end
		@(negedge ref_clk_in) attached_in <= 1'b1;
		repeat (5) @(negedge ref_clk_in);
		check(link_state_led_out, 1'b0);
		@(negedge ref_clk_in) device_mode_req_in <= 1'b1;
		repeat (5) @(negedge ref_clk_in);
		check({device_mode_out, link_state_led_out}, 2'b11);
		@(negedge ref_clk_in) configured_in <= 1'b1;
		repeat (5) @(negedge ref_clk_in);
		check(link_state_led_out, 1'b0);
		n = 0;
		repeat (250)
		begin
			b[0] = usb_ref_out;
			@(posedge ref_clk_in) b[1] = osc_input_in;
			@(negedge ref_clk_in) n += (usb_ref_out && !b[0]);
			check(osc_output_out, !b[1]);
		end
		check(n >= 47 && n <= 49, 1'b1);
		@(negedge ref_clk_in) ext_reset_in <= 1'b1;
		@(negedge ref_clk_in) check(reset_state_out_high, 1'b1);
		@(negedge ref_clk_in) ext_reset_in <= 1'b0;
		wait_hold();
		check(n >= HOLD && n <= HOLD + 3, 1'b1);
		do_reset(1'b1);
		check({serial_pin_oe_out, device_mode_out, serial_pin_out}, 3'b101);
		n = cq.size();
		i_host.wr(1'b1, 8'h81, 1'b0, 1'b1);
		check(cq.size(), n);
		pulse(4'h1);
		check(serial_pin_out, 1'b0);
		repeat (8) @(negedge ref_clk_in);
		check(serial_pin_out, 1'b0);
		close_out();
	end
endmodule
`default_nettype wire
